// ==== rtl/lst_pkg.sv ====
// Purpose: shared constants, types and helpers of the light sensor back end
// Assumes: 25 MHz system clock, byte-wide register map behind a two-wire serial slave
// Notes:   oscillator rates are derived from the system clock by division
`default_nettype none
package lst_pkg;
    // ------------------------------------------------------------
    // clock and oscillator rates
    // ------------------------------------------------------------
    localparam int CLK_KHZ      = 25000;
    localparam int OSC_FAST_KHZ = 655;
    localparam int OSC_SLOW_KHZ = 327;
    localparam int OSC_FAST_DIV = CLK_KHZ / OSC_FAST_KHZ;
    localparam int OSC_SLOW_DIV = 2 * OSC_FAST_DIV;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] REG_CMD    = 6'h00;
    localparam logic [5:0] REG_CTRL   = 6'h01;
    localparam logic [5:0] REG_UPPER  = 6'h02;
    localparam logic [5:0] REG_LOWER  = 6'h03;
    localparam logic [5:0] REG_RD_LO  = 6'h04;
    localparam logic [5:0] REG_RD_HI  = 6'h05;
    localparam logic [5:0] REG_CC_LO  = 6'h06;
    localparam logic [5:0] REG_CC_HI  = 6'h07;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CMD_EN_BIT     = 7;
    localparam int CMD_TIMING_BIT = 5;
    localparam int CTRL_FLAG_BIT  = 5;
    localparam int CTRL_RANGE_HI  = 3;
    localparam int ADDR_SYNC_BIT  = 7;
    localparam int ADDR_CLEAR_BIT = 6;
    localparam logic [7:0] CMD_RST   = 8'h00;
    localparam logic [3:0] CTRL_RST  = 4'h0;
    localparam logic [7:0] UPPER_RST = 8'hFF;
    localparam logic [7:0] LOWER_RST = 8'h00;
    // ------------------------------------------------------------
    // conversion lengths, persistence counts, full-scale spans
    // ------------------------------------------------------------
    localparam logic [16:0] WIDTH_CYC_0 = 17'h10000;
    localparam logic [16:0] WIDTH_CYC_1 = 17'h01000;
    localparam logic [16:0] WIDTH_CYC_2 = 17'h00100;
    localparam logic [16:0] WIDTH_CYC_3 = 17'h00010;
    localparam logic [4:0]  PERSIST_M_0 = 5'h01;
    localparam logic [4:0]  PERSIST_M_1 = 5'h04;
    localparam logic [4:0]  PERSIST_M_2 = 5'h08;
    localparam logic [4:0]  PERSIST_M_3 = 5'h10;
    localparam int FULL_SCALE_SPAN_1 = 973;
    localparam int FULL_SCALE_SPAN_2 = 3892;
    localparam int FULL_SCALE_SPAN_3 = 15568;
    localparam int FULL_SCALE_SPAN_4 = 62272;
    // ------------------------------------------------------------
    // serial slave states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        LST_IDLE, LST_ADDR, LST_ADDR_ACK, LST_REG, LST_REG_ACK,
        LST_WDATA, LST_WDATA_ACK, LST_RDATA, LST_RACK
    } lst_state_t;

    function automatic logic [16:0] width_cycles(input logic [1:0] code);
        unique case (code)
            2'b00: width_cycles = WIDTH_CYC_0;
            2'b01: width_cycles = WIDTH_CYC_1;
            2'b10: width_cycles = WIDTH_CYC_2;
            2'b11: width_cycles = WIDTH_CYC_3;
        endcase
    endfunction

    function automatic logic [4:0] persist_m(input logic [1:0] code);
        unique case (code)
            2'b00: persist_m = PERSIST_M_0;
            2'b01: persist_m = PERSIST_M_1;
            2'b10: persist_m = PERSIST_M_2;
            2'b11: persist_m = PERSIST_M_3;
        endcase
    endfunction

    function automatic logic [15:0] sat16(input logic [16:0] v);
        sat16 = v[16] ? 16'hFFFF : v[15:0];
    endfunction
endpackage
`default_nettype wire

// ==== rtl/lst_sync.sv ====
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk_i
// Notes:   first stage feeds only the second
`default_nettype none
module lst_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            meta <= '1;
            q_o  <= '1;
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/lst_osc.sv ====
// Purpose: dual-rate conversion oscillator as a one-cycle enable pulse
// Assumes: fast rate is the system clock divided by DIV_FAST
// Notes:   slow rate is exactly half the fast rate
`default_nettype none
module lst_osc #(
    parameter int DIV_FAST = lst_pkg::OSC_FAST_DIV
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // rate select
    input  wire logic fast_i,
    // enable pulse
    output logic      tick_o
);
    import lst_pkg::*;
    localparam logic [7:0] LIM_FAST = 8'(DIV_FAST - 1);
    localparam logic [7:0] LIM_SLOW = 8'(2 * DIV_FAST - 1);
    logic [7:0] cnt;
    logic       wrap;

    assign wrap = (cnt >= (fast_i ? LIM_FAST : LIM_SLOW));

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt    <= 8'h00;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt    <= wrap ? 8'h00 : cnt + 8'h01;
            tick_o <= wrap;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/lst_top.sv ====
// Purpose: light sensor back end: registers, integration timing, threshold interrupt
// Assumes: charge_i is the front-end count qualifier on clk_i; scl/sda are pins
// Notes:   sda is open drain; sda_oe_o high pulls the line low
//
// How it works
// - flag bit 5 set on threshold trigger
// - writing zero to flag clears it
// - bits 3:2 pick range index one to four
// - oscillator half rate for ranges one, two
// - trigger only after m consecutive out readings
// - bits 1:0 give m of 1,4,8,16
// - upper threshold resets to all ones
// - lower threshold resets zero, holds written byte
// - threshold byte is upper byte, low zero
// - reading registers refresh each integration end
// - reading low at 04, high at 05
// - timer counts oscillator ticks while integrating
// - timer captured with the reading
// - timer low at 06, high at 07
// - timer is full-scale count in external mode
// - internal mode integrates two-to-the-n ticks
// - control register readable and writable at 01
// - width bits pick 65536,4096,256,16 ticks
// - address bit 6 clears, bit 7 syncs
// - command bit 5 selects external timing
`default_nettype none
module lst_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2A   // arbitrary value
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // serial bus pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    // front end
    input  wire logic charge_i,
    // interrupt pin
    output logic      int_n_o
);
    import lst_pkg::*;

    // ------------------------------------------------------------
    // pin sampling and bus events
    // ------------------------------------------------------------
    logic [1:0] pins_s;
    logic       scl_s, sda_s, scl_q, sda_q;
    logic       scl_rise, scl_fall, bus_start, bus_stop;

    lst_sync #(.W(2)) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       ({scl_i, sda_i}),
        .q_o       (pins_s)
    );

    assign scl_s     = pins_s[1];
    assign sda_s     = pins_s[0];
    assign scl_rise  = scl_s & ~scl_q;
    assign scl_fall  = ~scl_s & scl_q;
    assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
    assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sda_o <= 1'b0;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            sda_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]  cmd, upper, lower;
    logic [3:0]  ctrl_cfg;
    logic        flag, next_flag;
    logic [15:0] reading, cycle_count;
    logic [7:0]  rd_byte;
    logic        wr_stb, addr_stb;
    logic [5:0]  wr_ptr, ptr;
    logic [7:0]  wr_data, addr_byte;

    always_comb
    begin
        unique case (ptr)
            REG_CMD:   rd_byte = cmd;
            REG_CTRL:  rd_byte = {2'b00, flag, 1'b0, ctrl_cfg};
            REG_UPPER: rd_byte = upper;
            REG_LOWER: rd_byte = lower;
            REG_RD_LO: rd_byte = reading[7:0];
            REG_RD_HI: rd_byte = reading[15:8];
            REG_CC_LO: rd_byte = cycle_count[7:0];
            REG_CC_HI: rd_byte = cycle_count[15:8];
            default:   rd_byte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    lst_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shift, tx;
    logic       byte_done, rw, mack;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state     <= LST_IDLE;
            bit_cnt   <= 3'h0;
            shift     <= 8'h00;
            tx        <= 8'h00;
            byte_done <= 1'b0;
            rw        <= 1'b0;
            mack      <= 1'b0;
            ptr       <= 6'h00;
            sda_oe_o  <= 1'b0;
            wr_stb    <= 1'b0;
            wr_ptr    <= 6'h00;
            wr_data   <= 8'h00;
            addr_stb  <= 1'b0;
            addr_byte <= 8'h00;
        end
        else
        begin
            wr_stb   <= 1'b0;
            addr_stb <= 1'b0;
            if (bus_start)
            begin
                state     <= LST_ADDR;
                bit_cnt   <= 3'h0;
                byte_done <= 1'b0;
                sda_oe_o  <= 1'b0;
            end
            else if (bus_stop)
            begin
                state    <= LST_IDLE;
                sda_oe_o <= 1'b0;
            end
            else if (scl_rise)
            begin
                unique case (state)
                    LST_ADDR, LST_REG, LST_WDATA:
                    begin
                        shift     <= {shift[6:0], sda_s};
                        bit_cnt   <= bit_cnt + 3'h1;
                        byte_done <= (bit_cnt == 3'h7);
                    end
                    LST_RDATA:
                    begin
                        bit_cnt   <= bit_cnt + 3'h1;
                        byte_done <= (bit_cnt == 3'h7);
                    end
                    LST_RACK: mack <= ~sda_s;
                    LST_IDLE, LST_ADDR_ACK, LST_REG_ACK, LST_WDATA_ACK: ;
                endcase
            end
            else if (scl_fall)
            begin
                unique case (state)
                    LST_ADDR:
                    if (byte_done)
                    begin
                        byte_done <= 1'b0;
                        if (shift[7:1] == DEV_ADDR)
                        begin
                            rw       <= shift[0];
                            state    <= LST_ADDR_ACK;
                            sda_oe_o <= 1'b1;
                        end
                        else
                            state <= LST_IDLE;
                    end
                    LST_ADDR_ACK, LST_RACK:
                    if (state == LST_RACK && !mack)
                    begin
                        state    <= LST_IDLE;
                        sda_oe_o <= 1'b0;
                    end
                    else if (state == LST_RACK || rw)
                    begin
                        state    <= LST_RDATA;
                        tx       <= {rd_byte[6:0], 1'b0};
                        sda_oe_o <= ~rd_byte[7];
                        ptr      <= ptr + 6'h01;
                    end
                    else
                    begin
                        state    <= LST_REG;
                        sda_oe_o <= 1'b0;
                    end
                    LST_REG:
                    if (byte_done)
                    begin
                        byte_done <= 1'b0;
                        addr_stb  <= 1'b1;
                        addr_byte <= shift;
                        ptr       <= shift[5:0];
                        state     <= LST_REG_ACK;
                        sda_oe_o  <= 1'b1;
                    end
                    LST_REG_ACK, LST_WDATA_ACK:
                    begin
                        state    <= LST_WDATA;
                        sda_oe_o <= 1'b0;
                    end
                    LST_WDATA:
                    if (byte_done)
                    begin
                        byte_done <= 1'b0;
                        wr_stb    <= 1'b1;
                        wr_ptr    <= ptr;
                        wr_data   <= shift;
                        ptr       <= ptr + 6'h01;
                        state     <= LST_WDATA_ACK;
                        sda_oe_o  <= 1'b1;
                    end
                    LST_RDATA:
                    if (byte_done)
                    begin
                        byte_done <= 1'b0;
                        state     <= LST_RACK;
                        sda_oe_o  <= 1'b0;
                    end
                    else
                    begin
                        sda_oe_o <= ~tx[7];
                        tx       <= {tx[6:0], 1'b0};
                    end
                    LST_IDLE: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cmd      <= CMD_RST;
            ctrl_cfg <= CTRL_RST;
            upper    <= UPPER_RST;
            lower    <= LOWER_RST;
        end
        else if (wr_stb)
        begin
            if (wr_ptr == REG_CMD)
                cmd <= wr_data;
            if (wr_ptr == REG_CTRL)
                ctrl_cfg <= wr_data[3:0];
            if (wr_ptr == REG_UPPER)
                upper <= wr_data;
            if (wr_ptr == REG_LOWER)
                lower <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // oscillator and integration
    // ------------------------------------------------------------
    logic        tick, running, ext_mode, adc_en, sync_cmd, end_int;
    logic [16:0] int_cnt, light_cnt, next_int, next_light;
    logic        inc;

    lst_osc u_osc (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .fast_i    (ctrl_cfg[CTRL_RANGE_HI]),
        .tick_o    (tick)
    );

    assign ext_mode = cmd[CMD_TIMING_BIT];
    assign adc_en   = cmd[CMD_EN_BIT];
    assign sync_cmd = addr_stb & addr_byte[ADDR_SYNC_BIT];
    assign inc      = tick & running & (int_cnt != 17'h1FFFF);

    always_comb
    begin
        next_int   = int_cnt + {16'h0000, inc};
        next_light = light_cnt + {16'h0000, inc & charge_i};
        end_int    = running & (ext_mode ? sync_cmd
                   : (tick && next_int == width_cycles(cmd[1:0])));
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !adc_en)
        begin
            running   <= 1'b0;
            int_cnt   <= 17'h00000;
            light_cnt <= 17'h00000;
        end
        else if (end_int)
        begin
            int_cnt   <= 17'h00000;
            light_cnt <= 17'h00000;
        end
        else if (!running)
            running <= ext_mode ? sync_cmd : 1'b1;
        else
        begin
            int_cnt   <= next_int;
            light_cnt <= next_light;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            reading     <= 16'h0000;
            cycle_count <= 16'h0000;
        end
        else if (end_int)
        begin
            reading     <= sat16(next_light);
            cycle_count <= sat16(next_int);
        end
    end

    // ------------------------------------------------------------
    // threshold window, persistence, flag and pin
    // ------------------------------------------------------------
    logic [15:0] new_read, upper_cmp, lower_cmp;
    logic        out_win, hit, set_evt, clr_evt;
    logic [4:0]  persist_cnt;

    always_comb
    begin
        new_read  = sat16(next_light);
        upper_cmp = {upper, 8'h00};
        lower_cmp = {lower, 8'h00};
        out_win   = (new_read > upper_cmp) || (new_read < lower_cmp);
        hit       = (persist_cnt + 5'h01) >= persist_m(ctrl_cfg[1:0]);
        set_evt   = end_int & out_win & hit;
        clr_evt   = (wr_stb & (wr_ptr == REG_CTRL) & ~wr_data[CTRL_FLAG_BIT])
                  | (addr_stb & addr_byte[ADDR_CLEAR_BIT]);
        next_flag = set_evt | (flag & ~clr_evt);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            persist_cnt <= 5'h00;
        else if (end_int)
            persist_cnt <= (out_win && !hit) ? persist_cnt + 5'h01 : 5'h00;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            flag    <= 1'b0;
            int_n_o <= 1'b1;
        end
        else
        begin
            flag    <= next_flag;
            int_n_o <= ~next_flag;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [7:0] gap;
    logic       gap_ok, fast_q;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            gap    <= 8'h00;
            gap_ok <= 1'b0;
            fast_q <= 1'b0;
        end
        else
        begin
            fast_q <= ctrl_cfg[CTRL_RANGE_HI];
            gap    <= tick ? 8'h00 : gap + 8'h01;
            if (ctrl_cfg[CTRL_RANGE_HI] != fast_q)
                gap_ok <= 1'b0;
            else if (tick)
                gap_ok <= 1'b1;
        end
    end

    a_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        end_int && out_win && hit |=> flag && !int_n_o)
        else $error("flag not set on persistent out-of-window reading");
    a_flag_wr_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_stb && wr_ptr == REG_CTRL && !wr_data[5] && !set_evt |=> !flag && int_n_o)
        else $error("flag not cleared by zero write");
    a_addr_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        addr_stb && addr_byte[6] && !set_evt |=> !flag)
        else $error("flag not cleared by clear address bit");
    a_pin_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !int_n_o && !clr_evt |=> !int_n_o)
        else $error("interrupt pin released without clear");
    a_inwin_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        end_int && !out_win && !clr_evt |=> persist_cnt == 5'h00 && $stable(flag))
        else $error("in-window reading did not reset persistence");
    a_pair_update: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        end_int |=> reading == $past(new_read) && cycle_count == sat16($past(next_int)))
        else $error("reading and timer not captured together");
    a_int_length: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        end_int && !ext_mode |=> cycle_count == sat16(width_cycles($past(cmd[1:0]))))
        else $error("internal integration length wrong");
    a_osc_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tick && gap_ok && $stable(ctrl_cfg[3]) |->
        gap == (ctrl_cfg[3] ? 8'(OSC_FAST_DIV - 1) : 8'(OSC_SLOW_DIV - 1)))
        else $error("oscillator period wrong for range");
    a_thr_reset: assert property (@(posedge clk_i)
        $fell(sys_rst_i) |-> upper == 8'hFF && lower == 8'h00)
        else $error("threshold reset values wrong");
    a_ext_sync: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        adc_en && ext_mode && running && sync_cmd |-> end_int ##1 int_cnt == 17'h00000)
        else $error("sync write did not end external integration");

    c_flag_rise: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(flag));
    c_ext_end:   cover property (@(posedge clk_i) disable iff (sys_rst_i) end_int && ext_mode);
    c_rd_data:   cover property (@(posedge clk_i) disable iff (sys_rst_i)
        state == LST_RDATA && ptr == REG_RD_HI);
    c_persist:   cover property (@(posedge clk_i) disable iff (sys_rst_i)
        set_evt && ctrl_cfg[1:0] == 2'b11);
endmodule
`default_nettype wire

// ==== testbench/lst_host.sv ====
// Purpose: two-wire bus master model
// Assumes: 8 system clocks per bus bit
// Notes:   sda released means pulled up
`default_nettype none
module lst_host #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    // clock and wire
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      pull_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic nak = 1'b0;
    initial scl_o = 1'b1;
    initial pull_o = 1'b0;
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic bt(input logic b, output logic r);
        w(2);
        pull_o = ~b;
        w(2);
        scl_o = 1'b1;
        w(4);
        r = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic st();
        w(2);
        pull_o = 1'b0;
        w(2);
        scl_o = 1'b1;
        w(4);
        pull_o = 1'b1;
        w(4);
        scl_o = 1'b0;
    endtask
    task automatic sp();
        w(2);
        pull_o = 1'b1;
        w(2);
        scl_o = 1'b1;
        w(4);
        pull_o = 1'b0;
        w(4);
    endtask
    task automatic by(input logic [7:0] d, input logic ck, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
        bt(1'b1, a);
        if (ck && a) nak = 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        st();
        by({ADDR, 1'b0}, 1'b1, q);
        by(a, 1'b1, q);
        by(d, 1'b1, q);
        sp();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        st();
        by({ADDR, 1'b0}, 1'b1, q);
        by(a, 1'b1, q);
        st();
        by({ADDR, 1'b1}, 1'b1, q);
        by(8'hFF, 1'b0, q);
        sp();
    endtask
endmodule
`default_nettype wire

// ==== testbench/lst_top_tb_top.sv ====
// Purpose: self-checking bench of the light sensor back end
// Assumes: host model on the serial pins
// Notes:   register model kept in mdl
`default_nettype none
module lst_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, sys_rst_i = 1, charge_i = 0, scl, pull, sda_o, sda_oe, int_n;
    wire logic sda = ~(pull | sda_oe);
    int miscompares = 0, comparisons = 0;
    logic [7:0] mdl [8];
    logic [7:0] q;
    always #20 clk_i = ~clk_i;
    lst_top #(.DEV_ADDR(7'h2A)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .charge_i(charge_i), .int_n_o(int_n));
    lst_host #(.ADDR(7'h2A)) host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
    task automatic complete_run();
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic rc(input logic [7:0] a);
        host.rd(a, q);
        chk("reg", mdl[a[2:0]], q);
    endtask
    task automatic wm(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        mdl[a[2:0]] = (a[2:0] == 3'h1) ? {4'h0, d[3:0]} : d;
    endtask
    task automatic wl(input logic v, input int n);
        for (int i = 0; i < n && int_n !== v; i++) @(negedge clk_i);
        chk("int_n", {7'h0, v}, {7'h0, int_n});
        if (int_n !== v) complete_run();
    endtask
    initial
    begin
        void'($urandom(46));
        mdl = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        repeat (3) @(negedge clk_i);
        sys_rst_i = 0;
        repeat (4) @(negedge clk_i);
        for (int a = 0; a < 8; a++) rc(8'(a));
        for (int k = 0; k < 4; k++)
        begin
            wm(8'h01, 8'(k * 5));
            rc(8'h01);
        end
        wm(8'h03, 8'($urandom));
        rc(8'h03);
        host.rd(8'h10, q);
        chk("rsv", 8'h00, q);
        wm(8'h03, 8'h01);
        wm(8'h01, 8'h0C);
        charge_i = 1;
        wm(8'h00, 8'h83);
        wl(1'b0, 3000);
        mdl[1] = 8'h2C;
        mdl[4] = 8'h10;
        mdl[6] = 8'h10;
        for (int a = 1; a < 8; a++) rc(8'(a));
        wm(8'h01, 8'h0F);
        wl(1'b1, 10);
        repeat (4000) @(negedge clk_i);
        chk("int_n", 8'h01, {7'h0, int_n});
        wl(1'b0, 8000);
        wm(8'h43, 8'h00);
        mdl[1] = 8'h0F;
        wl(1'b1, 10);
        repeat (2000) @(negedge clk_i);
        chk("int_n", 8'h01, {7'h0, int_n});
        rc(8'h01);
        // external timing: two sync writes exactly 26 fast ticks apart
        wm(8'h00, 8'h00);
        wm(8'h00, 8'hA0);
        wm(8'h80, 8'hA0);
        repeat (26 * lst_pkg::OSC_FAST_DIV - 240) @(negedge clk_i);
        wm(8'h80, 8'hA0);
        mdl[4] = 8'h1A;
        mdl[6] = 8'h1A;
        for (int a = 4; a < 8; a++) rc(8'(a));
        chk("int_n", 8'h01, {7'h0, int_n});
        chk("sda_o", 8'h00, {7'h0, sda_o});
        chk("ack", 8'h00, {7'h0, host.nak});
        complete_run();
    end
endmodule
`default_nettype wire
